// [hw/ihpd_params.svh]
// constants for the indexing and homing path decoder
`ifndef IHPD_PARAMS_SVH
`define IHPD_PARAMS_SVH
`define IHPD_TYPE_INDEX 4'hA
`define IHPD_TYPE_LSB 0
`define IHPD_DIR_LSB 6
`define IHPD_OVERLAP_ALLOW_BIT 5
`define IHPD_INS_BIT 4
`define IHPD_ACC_LSB 8
`define IHPD_SPD_LSB 16
`define IHPD_DLY_LSB 20
`define IHPD_UNIT_LSB 24
`define IHPD_AUTO_BIT 26
`define IHPD_BOOT_LSB 28
`define IHPD_PATH_LSB 0
`define IHPD_MAX_PULSE 32'h000FFFFF
`define IHPD_REG_RESET 32'h00000000
`endif

// [hw/ihpd_pkg.sv]
// types for the indexing and homing path decoder
package ihpd_pkg;
    typedef enum logic [4:0] {
        IHPD_IDLE = 5'h01,
        IHPD_BOOT = 5'h02,
        IHPD_HOME = 5'h04,
        IHPD_RAMP = 5'h08,
        IHPD_MOVE = 5'h10
    } ihpd_state_type;
    typedef enum logic [1:0] {
        IHPD_FWD = 2'h0,
        IHPD_REV = 2'h1,
        IHPD_SHORT = 2'h2,
        IHPD_DIR_BAD = 2'h3
    } ihpd_dir_type;
endpackage

// [hw/ihpd_reg_file.sv]
// four-word record store with registered read data
`timescale 1ns/1ps
module ihpd_reg_file (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [31:0] wr_data,
    input wire logic [1:0] rd_sel,
    output logic [31:0] rd_data,
    output logic [127:0] words
);
`include "ihpd_params.svh"
    logic [31:0] mem_q [4];
    // settings survive reset like stored parameters, so power-up homing can see them
    always_ff @(posedge CLK_SYS) begin
        if (wr_en) begin
            mem_q[wr_sel] <= wr_data;
        end
        if (!RESET_N) begin
            rd_data <= `IHPD_REG_RESET;
        end else begin
            rd_data <= mem_q[rd_sel];
        end
    end
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_flat
            assign words[g*32 +: 32] = mem_q[g];
        end
    endgenerate
endmodule

// [hw/ihpd_top.sv]
// indexing and homing path record decoder and sequencer
`timescale 1ns/1ps
module ihpd_top (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic REG_WR,
    input wire logic [1:0] REG_SEL,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic PATH_START,
    input wire logic MOTION_DONE,
    input wire logic HOME_SENSOR,
    input wire logic INDEX_PULSE,
    input wire logic STOPPED,
    input wire logic [31:0] POS_OFFSET,
    output logic MOVE_VALID,
    output logic [1:0] MOVE_DIR,
    output logic [1:0] SPEED_UNIT,
    output logic [3:0] SPEED_SELECT,
    output logic [3:0] DELAY_SELECT,
    output logic [7:0] ACCEL_SELECT,
    output logic [31:0] MOVE_TARGET,
    output logic MOVE_ABORT,
    output logic OVERLAP_ALLOW,
    output logic HOMING_ACTIVE,
    output logic RAMP_STOP,
    output logic [31:0] ORIGIN_COORD,
    output logic [5:0] NEXT_PATH,
    output logic NEXT_PATH_GO,
    output logic TARGET_ERROR
);
    import ihpd_pkg::*;
`include "ihpd_params.svh"
    typedef struct packed {
        ihpd_state_type st;
        logic [2:0] home_s1;
        logic [2:0] home_s2;
        logic boot_done;
        logic mv;
        logic [1:0] dir;
        logic [1:0] unit;
        logic [3:0] speed_select;
        logic [3:0] dly;
        logic [7:0] acc;
        logic [31:0] tgt;
        logic abort;
        logic overlap_allow;
        logic chain;
        logic homing;
        logic ramp;
        logic [31:0] origin;
        logic [5:0] next;
        logic go;
        logic terr;
    } ihpd_regs_type;
    ihpd_regs_type q, d;
    logic [127:0] words;
    logic [31:0] rd_data;
    logic [31:0] home_ctl, home_org, path_ctl, path_dat;
    ihpd_reg_file u_regs (
        .CLK_SYS(CLK_SYS),
        .RESET_N(RESET_N),
        .wr_en(REG_WR),
        .wr_sel(REG_SEL),
        .wr_data(REG_WDATA),
        .rd_sel(REG_SEL),
        .rd_data(rd_data),
        .words(words)
    );
    assign home_ctl = words[31:0];
    assign home_org = words[63:32];
    assign path_ctl = words[95:64];
    assign path_dat = words[127:96];
    // pin inputs pass two flops; home sensor, index pulse, stopped
    logic [2:0] pins_raw;
    assign pins_raw = {HOME_SENSOR, INDEX_PULSE, STOPPED};
    function automatic logic is_index(input logic [31:0] w);
        return w[`IHPD_TYPE_LSB +: 4] == `IHPD_TYPE_INDEX;
    endfunction
    logic start_ok;
    logic do_load;
    always_comb begin
        d = q;
        start_ok = PATH_START && is_index(path_ctl);
        do_load = 1'b0;
        d.home_s1 = pins_raw;
        d.home_s2 = q.home_s1;
        d.go = 1'b0;
        d.abort = 1'b0;
        case (q.st)
            IHPD_IDLE: begin
                d.mv = 1'b0;
                if (!q.boot_done) begin
                    d.boot_done = 1'b1;
                    if (home_ctl[`IHPD_BOOT_LSB +: 4] == 4'h1) begin
                        d.st = IHPD_HOME;
                        d.homing = 1'b1;
                        d.origin = home_org;
                    end
                end else if (start_ok) begin
                    do_load = 1'b1;
                end
            end
            IHPD_HOME: begin
                // sensor or index level high, after the two flops, ends the search
                if (q.home_s2[2] || q.home_s2[1]) begin
                    d.st = IHPD_RAMP;
                    d.ramp = 1'b1;
                end
            end
            IHPD_RAMP: begin
                if (q.home_s2[0]) begin
                    d.st = IHPD_IDLE;
                    d.ramp = 1'b0;
                    d.homing = 1'b0;
                    d.next = home_ctl[`IHPD_PATH_LSB +: 6];
                    d.go = home_ctl[`IHPD_PATH_LSB +: 6] != 6'h00;
                end
            end
            IHPD_MOVE: begin
                if (start_ok && path_ctl[`IHPD_INS_BIT]) begin
                    // replacement starts at once in place of the running record
                    d.abort = 1'b1;
                    do_load = 1'b1;
                end else if (start_ok && q.overlap_allow) begin
                    do_load = 1'b1;
                end else if (MOTION_DONE) begin
                    d.st = IHPD_IDLE;
                    d.mv = 1'b0;
                    d.go = q.chain;
                end
            end
            default: d.st = IHPD_IDLE;
        endcase
        if (do_load) begin
            if (path_dat > `IHPD_MAX_PULSE) begin
                d.terr = 1'b1;
                d.st = IHPD_IDLE;
                d.mv = 1'b0;
            end else begin
                d.terr = 1'b0;
                d.st = IHPD_MOVE;
                d.mv = 1'b1;
                d.dir = path_ctl[`IHPD_DIR_LSB +: 2];
                d.unit = path_ctl[`IHPD_UNIT_LSB +: 2];
                d.speed_select = path_ctl[`IHPD_SPD_LSB +: 4];
                d.dly = path_ctl[`IHPD_DLY_LSB +: 4];
                d.acc = path_ctl[`IHPD_ACC_LSB +: 8];
                d.tgt = 32'(path_dat + POS_OFFSET);
                d.overlap_allow = path_ctl[`IHPD_OVERLAP_ALLOW_BIT];
                d.chain = path_ctl[`IHPD_AUTO_BIT];
            end
        end
    end
    always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
            q <= '0;
            q.st <= IHPD_IDLE;
            REG_RDATA <= 32'h00000000;
        end else begin
            q <= d;
            REG_RDATA <= rd_data;
        end
    end
    // offset kept out of the homing origin; only moves use it
    always_comb begin
        MOVE_VALID = q.mv;
        MOVE_DIR = q.dir;
        SPEED_UNIT = q.unit;
        SPEED_SELECT = q.speed_select;
        DELAY_SELECT = q.dly;
        ACCEL_SELECT = q.acc;
        MOVE_TARGET = q.tgt;
        MOVE_ABORT = q.abort;
        OVERLAP_ALLOW = q.overlap_allow;
        HOMING_ACTIVE = q.homing;
        RAMP_STOP = q.ramp;
        ORIGIN_COORD = q.origin;
        NEXT_PATH = q.next;
        NEXT_PATH_GO = q.go;
        TARGET_ERROR = q.terr;
    end
    ramp_after_home_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (q.st == IHPD_HOME && (q.home_s2[2] || q.home_s2[1])) |=> RAMP_STOP)
        else $error("ramp not started after home detect");
    target_limit_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        $rose(MOVE_VALID) |-> $past(path_dat) <= `IHPD_MAX_PULSE)
        else $error("pulse target over limit");
    homing_moves_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        HOMING_ACTIVE |-> !MOVE_VALID)
        else $error("move while homing");
    abort_restart_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        MOVE_ABORT |-> (MOVE_VALID || TARGET_ERROR))
        else $error("replacement record not started");
    sequence s_start_taken;
        q.st == IHPD_IDLE && q.boot_done && PATH_START && is_index(path_ctl) && path_dat <= `IHPD_MAX_PULSE;
    endsequence
    sequence s_move_up;
        MOVE_VALID && !TARGET_ERROR;
    endsequence
    sequence s_home_done;
        q.st == IHPD_RAMP && q.home_s2[0];
    endsequence
    start_move_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        s_start_taken |=> s_move_up)
        else $error("index record not started");
    home_next_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        s_home_done |=> ((NEXT_PATH_GO == (NEXT_PATH != 6'h00)) && !HOMING_ACTIVE))
        else $error("follow-on path wrong after homing");
endmodule

// [dv/ihpd_motor_model.sv]
// motor and sensor model on the far side of the decoder
`timescale 1ns/1ps
module ihpd_motor_model (
    input wire logic CLK_SYS,
    input wire logic MOVE_VALID,
    input wire logic MOVE_ABORT,
    input wire logic HOMING_ACTIVE,
    input wire logic RAMP_STOP,
    input wire logic slow,
    output logic MOTION_DONE,
    output logic HOME_SENSOR,
    output logic INDEX_PULSE,
    output logic STOPPED
);
    int cnt = 0;
    int hcnt = 0;
    int rcnt = 0;
    initial MOTION_DONE = 1'b0;
    // an abort restarts the travel time, so a replaced move never finishes early
    always @(posedge CLK_SYS) begin
        cnt <= (MOVE_VALID && !MOVE_ABORT && !MOTION_DONE) ? cnt + 1 : 0;
        MOTION_DONE <= (cnt == (slow ? 20 : 3));
        hcnt <= HOMING_ACTIVE ? hcnt + 1 : 0;
        rcnt <= RAMP_STOP ? rcnt + 1 : 0;
    end
    assign HOME_SENSOR = (hcnt > 4);
    assign INDEX_PULSE = (hcnt == 6);
    // the ramp takes a few cycles before the shaft stands still
    assign STOPPED = !MOVE_VALID && (!HOMING_ACTIVE || rcnt > 3);
endmodule

// [dv/test_indexing_homing_path_decoder.sv]
// self-checking bench for the path record decoder
`timescale 1ns/1ps
module test_indexing_homing_path_decoder;
    logic CLK_SYS, RESET_N, REG_WR, PATH_START, MOTION_DONE, HOME_SENSOR, INDEX_PULSE, STOPPED;
    logic MOVE_VALID, MOVE_ABORT, OVERLAP_ALLOW, HOMING_ACTIVE, RAMP_STOP, NEXT_PATH_GO, TARGET_ERROR;
    logic [1:0] REG_SEL, MOVE_DIR, SPEED_UNIT;
    logic [3:0] SPEED_SELECT, DELAY_SELECT;
    logic [7:0] ACCEL_SELECT;
    logic [5:0] NEXT_PATH;
    logic [31:0] REG_WDATA, REG_RDATA, POS_OFFSET, MOVE_TARGET, ORIGIN_COORD;
    logic slow;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_abort = 0;
    ihpd_top i_dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_SEL(REG_SEL),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .PATH_START(PATH_START), .MOTION_DONE(MOTION_DONE),
        .HOME_SENSOR(HOME_SENSOR), .INDEX_PULSE(INDEX_PULSE), .STOPPED(STOPPED), .POS_OFFSET(POS_OFFSET),
        .MOVE_VALID(MOVE_VALID), .MOVE_DIR(MOVE_DIR), .SPEED_UNIT(SPEED_UNIT), .SPEED_SELECT(SPEED_SELECT),
        .DELAY_SELECT(DELAY_SELECT), .ACCEL_SELECT(ACCEL_SELECT), .MOVE_TARGET(MOVE_TARGET),
        .MOVE_ABORT(MOVE_ABORT), .OVERLAP_ALLOW(OVERLAP_ALLOW), .HOMING_ACTIVE(HOMING_ACTIVE),
        .RAMP_STOP(RAMP_STOP), .ORIGIN_COORD(ORIGIN_COORD), .NEXT_PATH(NEXT_PATH),
        .NEXT_PATH_GO(NEXT_PATH_GO), .TARGET_ERROR(TARGET_ERROR));
    ihpd_motor_model i_motor (.CLK_SYS(CLK_SYS), .MOVE_VALID(MOVE_VALID), .MOVE_ABORT(MOVE_ABORT),
        .HOMING_ACTIVE(HOMING_ACTIVE), .RAMP_STOP(RAMP_STOP), .slow(slow), .MOTION_DONE(MOTION_DONE),
        .HOME_SENSOR(HOME_SENSOR), .INDEX_PULSE(INDEX_PULSE), .STOPPED(STOPPED));
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) if (MOVE_ABORT === 1'b1) n_abort++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        @(posedge CLK_SYS);
        REG_WR <= 1'b1;
        REG_SEL <= s;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
    endtask
    // record is written whole, control then data, before the start pulse
    task automatic go(input logic [31:0] ctl, input logic [31:0] dat);
        wr(2'h2, ctl);
        wr(2'h3, dat);
        @(posedge CLK_SYS);
        PATH_START <= 1'b1;
        @(posedge CLK_SYS);
        PATH_START <= 1'b0;
        @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask
    task automatic wait_idle;
        repeat (40) if (MOVE_VALID === 1'b1) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk(MOVE_VALID, 0);
    endtask
    task automatic t_regs;
        for (int s = 0; s < 4; s++) begin
            wr(2'(s), 32'h0);
            repeat (3) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            chk(REG_RDATA, 0);
            wr(2'(s), 32'h00000F10 + s);
            repeat (3) @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            chk(REG_RDATA, 32'h00000F10 + s);
        end
        $display("test regs done");
    endtask
    task automatic t_index;
        POS_OFFSET <= 32'h10;
        for (int i = 0; i < 3; i++) begin
            go(32'h0035C70A | 32'(i << 24) | 32'(i << 6), 32'h1234 + i);
            chk(MOVE_VALID, 1);
            chk(MOVE_DIR, i);
            chk(SPEED_UNIT, i);
            chk({DELAY_SELECT, SPEED_SELECT, ACCEL_SELECT}, 32'h35C7);
            chk(MOVE_TARGET, 32'h1244 + i);
            wait_idle;
        end
        POS_OFFSET <= 32'h0;
        $display("test index done");
    endtask
    task automatic t_refuse;
        go(32'h0000000A, 32'h00100000);
        chk({TARGET_ERROR, MOVE_VALID}, 2'b10);
        go(32'h00000002, 32'h5);
        chk(MOVE_VALID, 0);
        go(32'h0000000A, 32'h000FFFFF);
        chk({MOVE_VALID, MOVE_TARGET[30:0]}, {1'b1, 31'h000FFFFF});
        wait_idle;
        $display("test refuse done");
    endtask
    task automatic t_chain(input logic a);
        int seen = 0;
        go(32'h0000000A | {5'h0, a, 26'h0}, 32'h64);
        repeat (30) begin
            @(negedge CLK_SYS);
            if (NEXT_PATH_GO === 1'b1) seen++;
        end
        chk(seen, a);
        $display("test chain done");
    endtask
    // slow motor keeps the first move running when the replacement arrives
    task automatic t_replace;
        go(32'h0000002A, 32'h40);
        chk(OVERLAP_ALLOW, 1);
        wait_idle;
        slow <= 1'b1;
        go(32'h0000000A, 32'h50);
        go(32'h0000001A, 32'h60);
        chk(n_abort, 1);
        chk({MOVE_VALID, MOVE_TARGET[30:0]}, {1'b1, 31'h00000060});
        slow <= 1'b0;
        wait_idle;
        $display("test replace done");
    endtask
    // settings survive reset, so a mid-run reset replays power-up homing
    task automatic t_home(input logic [5:0] p);
        int seen = 0;
        int ramp = 0;
        wr(2'h0, 32'h10000000 | 32'(p));
        wr(2'h1, 32'hFFFFFF00);
        POS_OFFSET <= 32'h77;
        @(posedge CLK_SYS);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk(HOMING_ACTIVE, 1);
        chk(ORIGIN_COORD, 32'hFFFFFF00);
        repeat (40) begin
            @(negedge CLK_SYS);
            if (NEXT_PATH_GO === 1'b1) seen++;
            if (RAMP_STOP === 1'b1) ramp++;
        end
        chk(ramp > 0, 1);
        chk(seen, p != 6'h00);
        chk(NEXT_PATH, p);
        chk(HOMING_ACTIVE, 0);
        POS_OFFSET <= 32'h0;
        $display("test home done");
    endtask
    task automatic summarize;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        n_mismatch++;
        summarize;
    end
    initial begin
        {RESET_N, REG_WR, PATH_START, slow} = 4'h0;
        REG_SEL = 2'h0;
        REG_WDATA = 32'h0;
        POS_OFFSET = 32'h0;
        repeat (16) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        t_regs;
        t_index;
        t_refuse;
        t_chain(1'b0);
        t_chain(1'b1);
        t_replace;
        t_home(6'h05);
        t_home(6'h00);
        summarize;
    end
endmodule
